// ===== verilog/gdc_params.svh
// Constants of the gauge configuration register bank: offsets, defaults, masks, timing.
// Assumes a single 25 MHz system clock; included by bare name.
`ifndef GDC_PARAMS_SVH
`define GDC_PARAMS_SVH

// ****************************************************************
// Parameter offsets
// ****************************************************************
`define GDC_OFS_GENERAL    8'h3a
`define GDC_OFS_ALERT      8'h3c

// ****************************************************************
// Reset values, writable bit masks and the IrDA encoding code
// ****************************************************************
`define GDC_GENERAL_RESET  16'h0028
`define GDC_ALERT_RESET    16'h0000
`define GDC_GENERAL_MASK   16'hfffd
`define GDC_ALERT_MASK     16'h3fff
`define GDC_ENC_IRDA       2'b01

// ****************************************************************
// Timing
// ****************************************************************
`define GDC_CLK_HZ         25000000
`define GDC_BAUD_FAST      9600
`define GDC_BAUD_SLOW      1200
`define GDC_BCAST_BASE_S   20
`define GDC_BCAST_STEP_S   20
`define GDC_SECS_PER_DAY   86400
`define GDC_BEEP_MS        100

`endif

// ===== verilog/gdc_pkg.sv
// Types of the gauge configuration register bank.
// Assumes gdc_params.svh for all numeric constants.
package gdc_pkg;

    // ****************************************************************
    // Register layouts, most significant field first
    // ****************************************************************
    typedef struct packed {
        logic       age_en;
        logic       learn_en;
        logic [1:0] enc;
        logic       baud_slow;
        logic       activated;
        logic [3:0] interval;
        logic [3:0] segs;
        logic       rsvd;
        logic       bcast_en;
    } gdc_general_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [2:0] under_beeps;
        logic [2:0] over_beeps;
        logic [1:0] seg3_beeps;
        logic [1:0] seg2_beeps;
        logic [1:0] seg1_beeps;
        logic [1:0] empty_beeps;
    } gdc_alert_t;

    // ****************************************************************
    // Parameter access request, gauge events and beep sequencer states
    // ****************************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  offset;
        logic [15:0] wdata;
    } gdc_par_req_t;

    typedef struct packed {
        logic       end_of_discharge;
        logic       undervolt;
        logic       overvolt;
        logic [2:0] seg_off;
        logic       empty;
    } gdc_evt_t;

    typedef enum logic [2:0] {
        GDC_BEEP_IDLE = 3'b001,
        GDC_BEEP_ON   = 3'b010,
        GDC_BEEP_GAP  = 3'b100
    } gdc_beep_t;

    // ****************************************************************
    // Whole state of the bank
    // ****************************************************************
    typedef struct packed {
        gdc_general_t gen;
        gdc_alert_t   alert;
        logic [15:0]  rdata;
        logic         rvalid;
        logic [31:0]  sec_cnt;
        logic [8:0]   bcast_sec;
        logic         bcast_pulse;
        logic [15:0]  baud_cnt;
        logic         baud_tick;
        logic [16:0]  day_sec;
        logic [7:0]   day_cnt;
        logic         derate_pulse;
        logic         learn_pulse;
        gdc_beep_t    beep;
        logic [2:0]   beeps_left;
        logic [31:0]  beep_tmr;
        logic         beep_out;
        logic [5:0]   pend;
    } gdc_state_t;

endpackage

// ===== verilog/gdc_config_regs.sv
// Gauge device configuration bank: general and audible-alert parameter words,
// with the broadcast, baud, derating, learning and beep logic they steer.
// Assumes requests and events come from logic on clk_sys, one cycle each.
//
// Function
// RULE1 - Broadcast status only while enable bit set
// RULE2 - Bar-graph segment count from four-bit field
// RULE3 - Broadcast spacing 20 s plus n times 20 s
// RULE4 - Single activation flag, cleared by default
// RULE5 - Baud 9600 when bit clear, else 1200
// RULE6 - Encoding 00 NRZ, 01 IrDA, rest reserved
// RULE7 - Learn capacity at end of discharge when enabled
// RULE8 - Derate capacity by aging rates when enabled
// RULE9 - Beep count on empty from lowest field
// RULE10 - Beep count per lowest three segments off
// RULE11 - Beep count on overvoltage, three-bit field
// RULE12 - Beep count on undervoltage, three-bit field
// RULE13 - Drop capacity 0.1 Ah per programmed days
// RULE14 - Host writes zero to reserved bits
// RULE15 - Fields load their defaults after reset
`timescale 1ns/1ps
`include "gdc_params.svh"

module gdc_config_regs #(
    parameter int SEC_CYCLES     = `GDC_CLK_HZ,
    parameter int BAUD_DIV_FAST  = `GDC_CLK_HZ / `GDC_BAUD_FAST,
    parameter int BAUD_DIV_SLOW  = `GDC_CLK_HZ / `GDC_BAUD_SLOW,
    parameter int SECS_PER_DAY   = `GDC_SECS_PER_DAY,
    parameter int BEEP_CYCLES    = (`GDC_CLK_HZ / 1000) * `GDC_BEEP_MS
) (
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire gdc_pkg::gdc_par_req_t par_req,
    input  wire gdc_pkg::gdc_evt_t   evt,
    input  wire logic [7:0]          early_derate_days,
    output logic [15:0]              par_rdata,
    output logic                     par_rvalid,
    output logic                     broadcast_req,
    output logic [3:0]               bar_segment_count,
    output logic                     device_activated,
    output logic                     baud_tick,
    output logic                     irda_encoding,
    output logic                     capacity_learning_enable,
    output logic                     capacity_aging_enable,
    output logic                     learn_capacity_pulse,
    output logic                     capacity_derate_pulse,
    output logic                     beep_out
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Counters are 16 and 17 bits wide; larger dividers would wrap
    if (BAUD_DIV_FAST < 1 || BAUD_DIV_SLOW < 1 || BAUD_DIV_SLOW > 65535 ||
        BAUD_DIV_FAST > 65535) begin : g_chk_baud
        $error("baud divider out of range");
    end
    if (SEC_CYCLES < 1 || BEEP_CYCLES < 1 || SECS_PER_DAY < 1 ||
        SECS_PER_DAY > 131071) begin : g_chk_time
        $error("timing parameter out of range");
    end

    // ****************************************************************
    // State and helpers
    // ****************************************************************
    gdc_pkg::gdc_state_t s_q;
    gdc_pkg::gdc_state_t s_d;
    logic                sec_tick;
    logic                day_tick;
    logic [8:0]          bcast_lim;
    logic [15:0]         baud_div;
    logic [5:0]          evt_vec;
    logic [5:0]          clr;
    logic [2:0]          sel_cnt;
    logic                sel_any;
    logic [2:0]          cnt_tbl [6];

    // Beep source counts, index 0 wins: overvoltage, undervoltage, empty, segments
    always_comb begin
        cnt_tbl[0] = s_q.alert.over_beeps;                         // RULE11
        cnt_tbl[1] = s_q.alert.under_beeps;                        // RULE12
        cnt_tbl[2] = {1'b0, s_q.alert.empty_beeps};                // RULE9
        cnt_tbl[3] = {1'b0, s_q.alert.seg1_beeps};                 // RULE10
        cnt_tbl[4] = {1'b0, s_q.alert.seg2_beeps};                 // RULE10
        cnt_tbl[5] = {1'b0, s_q.alert.seg3_beeps};                 // RULE10
        evt_vec    = {evt.seg_off[2], evt.seg_off[1], evt.seg_off[0],
                      evt.empty, evt.undervolt, evt.overvolt};
    end

    // Dividers derived from the stored configuration
    always_comb begin
        sec_tick  = (s_q.sec_cnt == 32'(SEC_CYCLES - 1));
        day_tick  = sec_tick && (s_q.day_sec == 17'(SECS_PER_DAY - 1));
        bcast_lim = 9'(`GDC_BCAST_BASE_S)
                  + 9'(s_q.gen.interval) * 9'(`GDC_BCAST_STEP_S);  // RULE3
        baud_div  = s_q.gen.baud_slow ? 16'(BAUD_DIV_SLOW)
                                      : 16'(BAUD_DIV_FAST);        // RULE5
    end

    // Lowest pending index picks the next beep burst
    always_comb begin
        sel_cnt = 3'h0;
        sel_any = 1'b0;
        clr     = 6'h00;
        for (int i = 5; i >= 0; i--) begin
            if (s_q.pend[i]) begin
                sel_cnt = cnt_tbl[i];
                sel_any = 1'b1;
                clr     = 6'h00;
                clr[i]  = 1'b1;
            end
        end
        if (s_q.beep != gdc_pkg::GDC_BEEP_IDLE) begin
            clr = 6'h00;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d              = s_q;
        s_d.rvalid       = 1'b0;
        s_d.bcast_pulse  = 1'b0;
        s_d.baud_tick    = 1'b0;
        s_d.derate_pulse = 1'b0;
        s_d.learn_pulse  = 1'b0;

        // Parameter writes; reserved bits are forced to zero on entry
        if (par_req.wr) begin
            if (par_req.offset == `GDC_OFS_GENERAL) begin
                s_d.gen = par_req.wdata & `GDC_GENERAL_MASK;       // RULE14
            end else if (par_req.offset == `GDC_OFS_ALERT) begin
                s_d.alert = par_req.wdata & `GDC_ALERT_MASK;       // RULE14
            end
        end

        // Reads answer one cycle later; unmapped offsets read zero
        if (par_req.rd) begin
            s_d.rvalid = 1'b1;
            if (par_req.offset == `GDC_OFS_GENERAL) begin
                s_d.rdata = s_q.gen;
            end else if (par_req.offset == `GDC_OFS_ALERT) begin
                s_d.rdata = s_q.alert;
            end else begin
                s_d.rdata = 16'h0000;
            end
        end

        // One-second enable
        s_d.sec_cnt = sec_tick ? 32'h0000_0000 : s_q.sec_cnt + 32'h0000_0001;

        // Broadcast interval; held at zero while disabled so a fresh enable
        // waits a whole interval
        if (!s_q.gen.bcast_en) begin
            s_d.bcast_sec = 9'h000;                                // RULE1
        end else if (sec_tick) begin
            if (s_q.bcast_sec >= bcast_lim - 9'h001) begin
                s_d.bcast_sec   = 9'h000;
                s_d.bcast_pulse = 1'b1;                            // RULE1
            end else begin
                s_d.bcast_sec = s_q.bcast_sec + 9'h001;            // RULE3
            end
        end

        // Serial bit-rate enable
        if (s_q.baud_cnt >= baud_div - 16'h0001) begin
            s_d.baud_cnt  = 16'h0000;
            s_d.baud_tick = 1'b1;                                  // RULE5
        end else begin
            s_d.baud_cnt = s_q.baud_cnt + 16'h0001;
        end

        // A new rate or interval restarts its count, so no period is cut short
        if (s_d.gen.baud_slow != s_q.gen.baud_slow) begin
            s_d.baud_cnt = 16'h0000;                               // RULE5
        end
        if (s_d.gen.interval != s_q.gen.interval) begin
            s_d.bcast_sec = 9'h000;                                // RULE3
        end

        // Day counter for aging; a zero day count never derates
        if (sec_tick) begin
            s_d.day_sec = day_tick ? 17'h0_0000 : s_q.day_sec + 17'h0_0001;
        end
        if (!s_q.gen.age_en) begin
            s_d.day_cnt = 8'h00;                                   // RULE8
        end else if (day_tick) begin
            if (early_derate_days != 8'h00 &&
                s_q.day_cnt + 8'h01 >= early_derate_days) begin
                s_d.day_cnt      = 8'h00;
                s_d.derate_pulse = 1'b1;                           // RULE13
            end else begin
                s_d.day_cnt = s_q.day_cnt + 8'h01;
            end
        end

        // Opportunistic capacity learning
        s_d.learn_pulse = evt.end_of_discharge && s_q.gen.learn_en; // RULE7

        // Pending beep events; a new event beats a same-cycle clear
        s_d.pend = (s_q.pend & ~clr) | evt_vec;

        // Beep burst sequencer
        unique case (s_q.beep)
            gdc_pkg::GDC_BEEP_IDLE: begin
                if (sel_any && sel_cnt != 3'h0) begin
                    s_d.beep       = gdc_pkg::GDC_BEEP_ON;
                    s_d.beeps_left = sel_cnt;                      // RULE9 RULE10 RULE11 RULE12
                    s_d.beep_tmr   = 32'(BEEP_CYCLES - 1);
                    s_d.beep_out   = 1'b1;
                end
            end
            gdc_pkg::GDC_BEEP_ON: begin
                if (s_q.beep_tmr == 32'h0000_0000) begin
                    s_d.beep       = gdc_pkg::GDC_BEEP_GAP;
                    s_d.beeps_left = s_q.beeps_left - 3'h1;
                    s_d.beep_tmr   = 32'(BEEP_CYCLES - 1);
                    s_d.beep_out   = 1'b0;
                end else begin
                    s_d.beep_tmr = s_q.beep_tmr - 32'h0000_0001;
                end
            end
            gdc_pkg::GDC_BEEP_GAP: begin
                if (s_q.beep_tmr != 32'h0000_0000) begin
                    s_d.beep_tmr = s_q.beep_tmr - 32'h0000_0001;
                end else if (s_q.beeps_left == 3'h0) begin
                    s_d.beep = gdc_pkg::GDC_BEEP_IDLE;
                end else begin
                    s_d.beep     = gdc_pkg::GDC_BEEP_ON;
                    s_d.beep_tmr = 32'(BEEP_CYCLES - 1);
                    s_d.beep_out = 1'b1;
                end
            end
            default: begin
                s_d.beep     = gdc_pkg::GDC_BEEP_IDLE;
                s_d.beep_out = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Defaults: broadcast off, ten segments, 20 s, 9600 NRZ, no learning or aging
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q            <= '0;
            s_q.gen        <= `GDC_GENERAL_RESET;                  // RULE15
            s_q.alert      <= `GDC_ALERT_RESET;                    // RULE15
            s_q.beep       <= gdc_pkg::GDC_BEEP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign par_rdata                = s_q.rdata;
    assign par_rvalid               = s_q.rvalid;
    assign broadcast_req            = s_q.bcast_pulse;
    assign bar_segment_count        = s_q.gen.segs;                // RULE2
    assign device_activated         = s_q.gen.activated;           // RULE4
    assign baud_tick                = s_q.baud_tick;
    assign irda_encoding            = (s_q.gen.enc == `GDC_ENC_IRDA); // RULE6
    assign capacity_learning_enable = s_q.gen.learn_en;            // RULE7
    assign capacity_aging_enable    = s_q.gen.age_en;              // RULE8
    assign learn_capacity_pulse     = s_q.learn_pulse;
    assign capacity_derate_pulse    = s_q.derate_pulse;
    assign beep_out                 = s_q.beep_out;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic first_q;
    // Marks the first clock after reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    sequence seq_gen_wr;
        par_req.wr && par_req.offset == `GDC_OFS_GENERAL;
    endsequence

    sequence seq_beep_start;
        s_q.beep == gdc_pkg::GDC_BEEP_IDLE && sel_any && sel_cnt != 3'h0;
    endsequence

    a_bcast_gate: assert property (                                 // RULE1
        broadcast_req |-> $past(s_q.gen.bcast_en) && s_q.bcast_sec == 9'h000)
        else $error("broadcast while disabled");
    a_seg_field: assert property (                                  // RULE2
        seq_gen_wr |=> bar_segment_count == $past(par_req.wdata[5:2]))
        else $error("segment count not taken");
    a_bcast_space: assert property (                                // RULE3
        broadcast_req |-> $past(s_q.bcast_sec) == $past(bcast_lim) - 9'h001)
        else $error("broadcast interval wrong");
    a_activate_flag: assert property (                              // RULE4
        seq_gen_wr |=> device_activated == $past(par_req.wdata[10]))
        else $error("activation flag not taken");
    a_baud_period: assert property (                                // RULE5
        baud_tick |-> $past(s_q.baud_cnt) == $past(baud_div) - 16'h0001)
        else $error("baud tick period wrong");
    a_enc_select: assert property (                                 // RULE6
        seq_gen_wr |=> irda_encoding == ($past(par_req.wdata[13:12]) == 2'b01))
        else $error("encoding select wrong");
    a_learn_gate: assert property (                                 // RULE7
        learn_capacity_pulse |-> $past(evt.end_of_discharge && s_q.gen.learn_en))
        else $error("learning without enable");
    a_derate_gate: assert property (                                // RULE8 RULE13
        capacity_derate_pulse |-> $past(s_q.gen.age_en && day_tick))
        else $error("derate without aging day");
    a_beep_load: assert property (                                  // RULE9 RULE10 RULE11 RULE12
        seq_beep_start |=> beep_out && s_q.beeps_left == $past(sel_cnt))
        else $error("beep burst count wrong");
    a_beep_end: assert property (                                   // RULE9 RULE10 RULE11 RULE12
        s_q.beep == gdc_pkg::GDC_BEEP_ON && s_q.beep_tmr == 32'h0000_0000
        |=> !beep_out && s_q.beeps_left == $past(s_q.beeps_left) - 3'h1)
        else $error("beep not counted down");
    a_reset_dflt: assert property (                                 // RULE15
        first_q |-> s_q.gen == `GDC_GENERAL_RESET && s_q.alert == `GDC_ALERT_RESET)
        else $error("defaults not loaded");
    a_rsvd_zero: assert property (                                  // RULE14
        s_q.gen.rsvd == 1'b0 && s_q.alert.rsvd == 2'b00)
        else $error("reserved bit set");

endmodule

// ===== verif/gdc_host_model.sv
// Host model for the gauge configuration bank: whole-word parameter writes and reads.
// Assumes the bank samples requests on the rising edge of clk_sys.
`timescale 1ns/1ps
`include "gdc_params.svh"

module gdc_host_model (
    input  wire logic                  clk_sys,
    input  wire logic [15:0]           par_rdata,
    input  wire logic                  par_rvalid,
    output gdc_pkg::gdc_par_req_t      par_req
);
    // ****************************************************************
    // Request tasks
    // ****************************************************************
    // Idle request at time zero
    initial par_req = '0;

    // Reserved bits and reserved encodings never leave the host
    function automatic logic [15:0] legal(input logic [7:0] ofs, input logic [15:0] d);
        if (ofs == `GDC_OFS_ALERT) begin
            return d & `GDC_ALERT_MASK;
        end
        return (ofs == `GDC_OFS_GENERAL) ? (d & 16'hdffd) : d;
    endfunction

    // Released lines show the inverse, so stale data cannot pass for fresh
    task automatic release_bus;
        par_req.wr     = 1'b0;
        par_req.rd     = 1'b0;
        par_req.offset = ~par_req.offset;
        par_req.wdata  = ~par_req.wdata;
    endtask

    // One-cycle write strobe, held across the sampling edge
    task automatic write_word(input logic [7:0] ofs, input logic [15:0] d);
        @(negedge clk_sys);
        par_req.wr     = 1'b1;
        par_req.offset = ofs;
        par_req.wdata  = legal(ofs, d);
        @(negedge clk_sys);
        release_bus();
    endtask

    // Read answer is registered at the request edge
    task automatic read_word(input logic [7:0] ofs, output logic [15:0] d, output logic ok);
        @(negedge clk_sys);
        par_req.rd     = 1'b1;
        par_req.offset = ofs;
        @(posedge clk_sys);
        #1;
        ok = par_rvalid;
        d  = par_rdata;
        @(negedge clk_sys);
        release_bus();
    endtask
endmodule

// ===== verif/gdc_config_regs_tb.sv
// Self-checking bench for the gauge configuration bank.
// Assumes shortened second, day, baud and beep counts set at the instance.
`timescale 1ns/1ps
`include "gdc_params.svh"

module gdc_config_regs_tb;
    logic                  clk_sys, rstn, par_rvalid, broadcast_req, device_activated;
    logic                  baud_tick, irda_encoding, capacity_learning_enable;
    logic                  capacity_aging_enable, learn_capacity_pulse, capacity_derate_pulse;
    logic                  beep_out;
    logic [3:0]            bar_segment_count;
    logic [7:0]            early_derate_days;
    logic [15:0]           par_rdata;
    gdc_pkg::gdc_par_req_t par_req;
    gdc_pkg::gdc_evt_t     evt;
    int                    mismatches, tests_run, n, i;
    int                    beep_exp[6] = '{2, 1, 2, 3, 5, 6};

    // Short counts keep the run to a few thousand cycles
    gdc_config_regs #(.SEC_CYCLES(10), .BAUD_DIV_FAST(4), .BAUD_DIV_SLOW(8),
        .SECS_PER_DAY(3), .BEEP_CYCLES(3)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .par_req(par_req), .evt(evt),
        .early_derate_days(early_derate_days), .par_rdata(par_rdata),
        .par_rvalid(par_rvalid), .broadcast_req(broadcast_req),
        .bar_segment_count(bar_segment_count), .device_activated(device_activated),
        .baud_tick(baud_tick), .irda_encoding(irda_encoding),
        .capacity_learning_enable(capacity_learning_enable),
        .capacity_aging_enable(capacity_aging_enable),
        .learn_capacity_pulse(learn_capacity_pulse),
        .capacity_derate_pulse(capacity_derate_pulse), .beep_out(beep_out));

    gdc_host_model host (.clk_sys(clk_sys), .par_rdata(par_rdata),
        .par_rvalid(par_rvalid), .par_req(par_req));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic read_check(input logic [7:0] ofs, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.read_word(ofs, d, ok);
        check({31'h0, ok}, 32'h1);
        check({16'h0, d}, {16'h0, exp});
    endtask

    // Cycles between two pulses; a missing pulse counts a mismatch and ends the run
    task automatic pulse_gap(ref logic s, input int lim, output int gap);
        int k;
        for (k = 0; k < lim && s !== 1'b1; k++) @(negedge clk_sys);
        @(negedge clk_sys);
        for (gap = 1; gap < lim && s !== 1'b1; gap++) @(negedge clk_sys);
        if (k == lim || gap == lim) begin
            mismatches++;
            $display("unexpected at %0t: pulse wait ran out", $time);
            tally_and_finish();
        end
    endtask

    // Rising edges seen over a window, a level already high counts once
    task automatic count_rises(ref logic s, input int cyc, output int cnt);
        logic last;
        cnt  = (s === 1'b1) ? 1 : 0;
        last = s;
        repeat (cyc) begin
            @(negedge clk_sys);
            if (s === 1'b1 && last !== 1'b1) cnt++;
            last = s;
        end
    endtask

    // One-cycle event pulse driven off the sampling edge
    task automatic fire(input logic [6:0] mask);
        @(negedge clk_sys);
        evt = gdc_pkg::gdc_evt_t'(mask);
        @(negedge clk_sys);
        evt = '0;
    endtask

    // ****************************************************************
    // Clock and main sequence
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        rstn = 1'b0;
        evt = '0;
        early_derate_days = 8'h02;
        mismatches = 0;
        tests_run = 0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        check(bar_segment_count, 32'ha);
        check({device_activated, irda_encoding, capacity_learning_enable,
            capacity_aging_enable}, 32'h0);
        read_check(`GDC_OFS_GENERAL, `GDC_GENERAL_RESET);
        read_check(`GDC_OFS_ALERT, `GDC_ALERT_RESET);
        pulse_gap(baud_tick, 50, n);
        check(n, 32'h4);
        count_rises(broadcast_req, 250, n);
        check(n, 32'h0);
        $display("test defaults done");

        // Every general field away from its default at once
        host.write_word(`GDC_OFS_GENERAL, 16'hdc5d);
        read_check(`GDC_OFS_GENERAL, 16'hdc5d);
        check({bar_segment_count, device_activated, irda_encoding}, 32'h1f);
        check({capacity_learning_enable, capacity_aging_enable}, 32'h3);
        pulse_gap(baud_tick, 50, n);
        check(n, 32'h8);
        pulse_gap(broadcast_req, 1000, n);
        check(n, 32'd400);
        fire(7'h40);
        count_rises(learn_capacity_pulse, 5, n);
        check(n, 32'h1);
        pulse_gap(capacity_derate_pulse, 200, n);
        check(n, 32'd60);
        $display("test general fields done");

        // Back to NRZ, fast baud, features off
        host.write_word(`GDC_OFS_GENERAL, 16'h0424);
        check({bar_segment_count, device_activated, irda_encoding}, 32'h26);
        pulse_gap(baud_tick, 50, n);
        check(n, 32'h4);
        fire(7'h40);
        count_rises(learn_capacity_pulse, 5, n);
        check(n, 32'h0);
        count_rises(capacity_derate_pulse, 150, n);
        check(n, 32'h0);
        count_rises(broadcast_req, 500, n);
        check(n, 32'h0);
        $display("test features off done");

        // Each alert kind alone, then a zero count, then a repeat that
        // lands after its burst started and so is served a second time
        host.write_word(`GDC_OFS_ALERT, 16'h35e6);
        read_check(`GDC_OFS_ALERT, 16'h35e6);
        for (i = 0; i < 6; i++) begin
            fire(7'h01 << i);
            count_rises(beep_out, 60, n);
            check(n, beep_exp[i]);
        end
        host.write_word(`GDC_OFS_ALERT, 16'h35e4);
        fire(7'h01);
        count_rises(beep_out, 30, n);
        check(n, 32'h0);
        fire(7'h10);
        fire(7'h10);
        count_rises(beep_out, 60, n);
        check(n, 32'ha);
        $display("test alerts done");

        // Unmapped offsets, then a second reset
        host.write_word(8'h50, 16'hffff);
        read_check(8'h3b, 16'h0000);
        read_check(`GDC_OFS_GENERAL, 16'h0424);
        @(negedge clk_sys);
        rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        read_check(`GDC_OFS_GENERAL, `GDC_GENERAL_RESET);
        read_check(`GDC_OFS_ALERT, `GDC_ALERT_RESET);
        $display("test unmapped and reset done");
        tally_and_finish();
    end
endmodule
